// file: ssc_pkg.sv
// ssc_pkg: shared constants and types of the shading set controller.
// assumes a 125 MHz core clock and a 12-bit pixel stream from the sensor path.
package ssc_pkg;

   // geometry and widths
   localparam int PIX_W = 12;
   localparam int IDX_W = 11;
   localparam int AW = 12;
   localparam int DW = 24;
   localparam int FRAC = 10;
   localparam logic [IDX_W:0] NPIX_C = 12'h800;

   // correction type index and set selector codes
   localparam logic TYPE_OFFSET = 1'b0;
   localparam logic TYPE_GAIN = 1'b1;
   localparam logic SET_FACTORY = 1'b0;
   localparam logic SET_OPERATOR = 1'b1;

   // create control values
   localparam logic CREATE_OFF = 1'b0;
   localparam logic SINGLE_SHOT_TRIGGER_VALUE = 1'b1;

   // factory sets: fixed constants, never writable
   localparam logic [15:0] FAC_OFF = 16'h0010;
   localparam logic [15:0] FAC_GAIN = 16'h0400;
   localparam logic [15:0] GAIN_UNITY = 16'h0400;
   localparam logic [15:0] OFF_NEUTRAL = 16'h0000;
   localparam logic [23:0] GAIN_REF_Q = 24'h3C_C800;
   localparam logic [PIX_W-1:0] PIX_MAX = 12'hFFF;

   // acquisition count and line rate threshold
   localparam int MIN_LINES_LOG2_DEF = 11;
   localparam int CLK_MHZ = 125;
   localparam int LINE_FAST_US = 10000;
   localparam int LINE_FAST_CYC = LINE_FAST_US * CLK_MHZ;

   typedef enum logic [1:0] {
      ST_NO_ERROR = 2'b00,
      ST_STARTUP_ERROR = 2'b01,
      ST_ACTIVATE_ERROR = 2'b10,
      ST_CREATE_ERROR = 2'b11
   } ssc_status_t;

   typedef enum logic [2:0] {
      SQ_IDLE = 3'b000,
      SQ_CLEAR = 3'b001,
      SQ_ACCUM = 3'b010,
      SQ_BUILD = 3'b011,
      SQ_ACT = 3'b100
   } ssc_state_t;

endpackage : ssc_pkg

// file: ssc_mem_if.sv
// ssc_mem_if: one simple dual-port memory port (write side, read side).
// assumes both sides run on core_clk.
`timescale 1ns/10ps
`default_nettype none
interface ssc_mem_if #(
   parameter int AW = 12,
   parameter int DW = 24
);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport owner (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ssc_mem_if
`default_nettype wire

// file: ssc_mem.sv
// ssc_mem: simple dual-port memory with registered read data.
// assumes one write and one read per cycle; no reset of contents.
`timescale 1ns/10ps
`default_nettype none
module ssc_mem #(
   parameter int AW = 12,
   parameter int DW = 24
) (
   input wire logic core_clk,
   ssc_mem_if.mem port
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   // read returns old data when both ports hit the same word
   always_ff @(posedge core_clk) begin
      if (port.we) begin
         store[port.waddr] <= port.wdata;
      end
      port.rdata <= store[port.raddr];
   end
endmodule : ssc_mem
`default_nettype wire

// file: ssc_shading_ctl.sv
// ssc_shading_ctl: shading set store, creation, activation and correction.
// assumes control and pixel inputs come from core_clk logic; resetn is asynchronous.
`timescale 1ns/10ps
`default_nettype none
module ssc_shading_ctl import ssc_pkg::*; #(
   parameter int MIN_LINES_LOG2 = MIN_LINES_LOG2_DEF,
   parameter int FAST_PERIOD_CYC = LINE_FAST_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [1:0] shade_enable,
   input wire logic [1:0] set_select,
   input wire logic [1:0] startup_set,
   input wire logic [1:0] activate,
   input wire logic [1:0] create_write,
   input wire logic create_write_value,
   output logic [1:0] create_ctl,
   output logic [3:0] shade_status,
   output logic busy,
   input wire logic [IDX_W-1:0] region_horizontal_start,
   input wire logic [IDX_W:0] region_width,
   input wire logic pix_valid,
   input wire logic [PIX_W-1:0] pix_data,
   input wire logic [IDX_W-1:0] pix_index,
   input wire logic line_done,
   output logic corr_valid,
   output logic [PIX_W-1:0] corr_data,
   output logic [IDX_W-1:0] corr_index
);
   // reset release through two flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ssc_mem_if #(.AW(AW), .DW(DW)) nv_if ();
   ssc_mem_if #(.AW(IDX_W), .DW(DW)) acc_if ();
   ssc_mem_if #(.AW(IDX_W), .DW(DW)) wo_if ();
   ssc_mem_if #(.AW(IDX_W), .DW(DW)) wg_if ();
   // nonvolatile store of both operator sets, type bit on top
   ssc_mem #(.AW(AW), .DW(DW)) u_nv (.core_clk(core_clk), .port(nv_if));
   ssc_mem #(.AW(IDX_W), .DW(DW)) u_acc (.core_clk(core_clk), .port(acc_if));
   ssc_mem #(.AW(IDX_W), .DW(DW)) u_wo (.core_clk(core_clk), .port(wo_if));
   ssc_mem #(.AW(IDX_W), .DW(DW)) u_wg (.core_clk(core_clk), .port(wg_if));

   ssc_state_t state;
   ssc_status_t status [2];
   logic [IDX_W:0] widx;
   logic ctype;
   logic act_type;
   logic [15:0] lines;
   logic [1:0] pend_act;
   logic [1:0] boot;
   logic [1:0] nv_valid;
   logic [IDX_W:0] reg_lo [2];
   logic [IDX_W:0] reg_hi [2];
   logic rd_v;
   logic [IDX_W-1:0] rd_idx;
   logic acc_v;
   logic [IDX_W-1:0] acc_idx;
   logic [PIX_W-1:0] acc_pix;
   logic [31:0] per_cnt;
   logic fast;
   logic sh_fast;
   logic [PIX_W-1:0] lmin;
   logic [PIX_W-1:0] lmax;
   logic ratio_bad;

   // request decode
   logic [1:0] trig;
   logic trig_t;
   logic walk_end;
   logic [15:0] min_lines;
   logic last_line;
   logic in_acc_reg;
   logic act_set;
   logic act_ok;
   logic act_err;
   logic ratio_fail;
   assign trig = create_write & {2{create_write_value == SINGLE_SHOT_TRIGGER_VALUE}};
   assign trig_t = trig[0] ? TYPE_OFFSET : TYPE_GAIN;
   assign walk_end = (widx == NPIX_C);
   // faster lines give a noisier mean, so twice as many are taken
   assign min_lines = fast ? 16'(1 << (MIN_LINES_LOG2 + 1)) : 16'(1 << MIN_LINES_LOG2);
   assign last_line = (lines == min_lines - 16'h0001);
   assign in_acc_reg = ({1'b0, pix_index} >= reg_lo[ctype]) && ({1'b0, pix_index} < reg_hi[ctype]);
   assign act_set = boot[act_type] ? startup_set[act_type] : set_select[act_type];
   assign act_ok = (act_set == SET_OPERATOR) && nv_valid[act_type];
   assign act_err = (act_set == SET_OPERATOR) && !nv_valid[act_type];
   assign ratio_fail = ({2'b00, lmin} << 2) <= {2'b00, lmax};
   assign busy = (state != SQ_IDLE);

   // build arithmetic: mean of accumulated lines
   logic [DW-1:0] avg;
   logic [15:0] off_val;
   logic [15:0] gain_val;
   logic [DW-1:0] quot;
   assign avg = sh_fast ? (acc_if.rdata >> (MIN_LINES_LOG2 + 1)) : (acc_if.rdata >> MIN_LINES_LOG2);
   // one divider per set build; area traded for a simple sequencer
   assign quot = (avg == '0) ? {DW{1'b1}} : GAIN_REF_Q / avg;
   assign off_val = avg[15:0] - FAC_OFF;
   assign gain_val = (quot > DW'(16'hFFFF)) ? 16'hFFFF : quot[15:0];

   // memory port steering
   assign nv_if.raddr = {act_type, widx[IDX_W-1:0]};
   assign nv_if.we = rd_v && (state == SQ_BUILD);
   assign nv_if.waddr = {ctype, rd_idx};
   assign nv_if.wdata = {8'h00, (ctype == TYPE_GAIN) ? gain_val : off_val};
   assign acc_if.raddr = (state == SQ_BUILD) ? widx[IDX_W-1:0] : pix_index;
   assign acc_if.we = ((state == SQ_CLEAR) && !walk_end) || acc_v;
   assign acc_if.waddr = acc_v ? acc_idx : widx[IDX_W-1:0];
   assign acc_if.wdata = acc_v ? acc_if.rdata + DW'(acc_pix) : '0;
   assign wo_if.we = rd_v && (state == SQ_ACT) && (act_type == TYPE_OFFSET);
   assign wg_if.we = rd_v && (state == SQ_ACT) && (act_type == TYPE_GAIN);
   assign wo_if.waddr = rd_idx;
   assign wg_if.waddr = rd_idx;
   assign wo_if.wdata = act_ok ? nv_if.rdata : {8'h00, OFF_NEUTRAL};
   assign wg_if.wdata = act_ok ? nv_if.rdata : {8'h00, GAIN_UNITY};
   assign wo_if.raddr = pix_index;
   assign wg_if.raddr = pix_index;

   // line period measurement for the rate-dependent count
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         per_cnt <= 32'h0000_0000;
         fast <= 1'b0;
      end else if (line_done) begin
         fast <= (per_cnt < 32'(FAST_PERIOD_CYC));
         per_cnt <= 32'h0000_0000;
      end else if (per_cnt < 32'(FAST_PERIOD_CYC)) begin
         per_cnt <= per_cnt + 32'h0000_0001;
      end
   end

   // accumulate pipeline and per-line brightness spread
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_v <= 1'b0;
         acc_idx <= '0;
         acc_pix <= '0;
         lmin <= PIX_MAX;
         lmax <= '0;
      end else begin
         acc_v <= (state == SQ_ACCUM) && pix_valid && in_acc_reg;
         acc_idx <= pix_index;
         acc_pix <= pix_data;
         if (line_done) begin
            lmin <= PIX_MAX;
            lmax <= '0;
         end else if ((state == SQ_ACCUM) && pix_valid && in_acc_reg) begin
            lmin <= (pix_data < lmin) ? pix_data : lmin;
            lmax <= (pix_data > lmax) ? pix_data : lmax;
         end
      end
   end

   // sequencer: clear, accumulate, build, activate
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SQ_IDLE;
         widx <= '0;
         ctype <= TYPE_OFFSET;
         act_type <= TYPE_OFFSET;
         lines <= 16'h0000;
         create_ctl <= {CREATE_OFF, CREATE_OFF};
         pend_act <= 2'b11;
         boot <= 2'b11;
         nv_valid <= 2'b00;
         reg_lo <= '{default: '0};
         reg_hi <= '{default: NPIX_C};
         status <= '{default: ST_NO_ERROR};
         rd_v <= 1'b0;
         rd_idx <= '0;
         sh_fast <= 1'b0;
         ratio_bad <= 1'b0;
      end else begin
         rd_v <= ((state == SQ_ACT) || (state == SQ_BUILD)) && !walk_end;
         rd_idx <= widx[IDX_W-1:0];
         pend_act <= pend_act | activate;
         if (state != SQ_IDLE && !walk_end) begin
            widx <= widx + 12'h001;
         end
         // retrigger of the running type is ignored while its create_ctl bit is set (clear, accumulate); otherwise it is refused, as is the other type
         if (state != SQ_IDLE && |(trig & ~create_ctl)) begin
            status[trig_t] <= ST_CREATE_ERROR;
         end
         case (state)
            SQ_IDLE: begin
               widx <= '0;
               if (|trig) begin
                  if (set_select[trig_t] == SET_FACTORY) begin
                     status[trig_t] <= ST_CREATE_ERROR;
                  end else begin
                     create_ctl[trig_t] <= SINGLE_SHOT_TRIGGER_VALUE;
                     ctype <= trig_t;
                     reg_lo[trig_t] <= {1'b0, region_horizontal_start};
                     reg_hi[trig_t] <= {1'b0, region_horizontal_start} + region_width;
                     state <= SQ_CLEAR;
                  end
               end else if (|pend_act) begin
                  act_type <= pend_act[0] ? TYPE_OFFSET : TYPE_GAIN;
                  state <= SQ_ACT;
               end
            end
            SQ_CLEAR: begin
               if (walk_end) begin
                  lines <= 16'h0000;
                  ratio_bad <= 1'b0;
                  state <= SQ_ACCUM;
               end
            end
            SQ_ACCUM: begin
               if (line_done) begin
                  lines <= lines + 16'h0001;
                  if (ctype == TYPE_GAIN && ratio_fail) begin
                     ratio_bad <= 1'b1;
                  end
                  if (last_line) begin
                     create_ctl[ctype] <= CREATE_OFF;
                     sh_fast <= fast;
                     widx <= '0;
                     state <= SQ_BUILD;
                  end
               end
            end
            SQ_BUILD: begin
               if (walk_end) begin
                  nv_valid[ctype] <= 1'b1;
                  status[ctype] <= ratio_bad ? ST_CREATE_ERROR : ST_NO_ERROR;
                  state <= SQ_IDLE;
               end
            end
            SQ_ACT: begin
               if (walk_end) begin
                  if (act_err) begin
                     status[act_type] <= boot[act_type] ? ST_STARTUP_ERROR : ST_ACTIVATE_ERROR;
                  end else begin
                     status[act_type] <= ST_NO_ERROR;
                  end
                  pend_act[act_type] <= activate[act_type]; // a new request wins
                  boot[act_type] <= 1'b0;
                  state <= SQ_IDLE;
               end
            end
            default: state <= SQ_IDLE;
         endcase
      end
   end
   assign shade_status = {status[1], status[0]};

   // correction: factory constant whenever its shade_enable bit is set, working-memory modifier on top
   logic v1;
   logic [PIX_W-1:0] pix1;
   logic [IDX_W-1:0] idx1;
   logic in_o;
   logic in_g;
   logic [15:0] off_mod;
   logic [15:0] gain_mod;
   logic signed [17:0] off_sum;
   logic [PIX_W-1:0] oc;
   logic [43:0] prod;
   logic [43:0] gprod;
   logic [PIX_W-1:0] gc;
   assign in_o = ({1'b0, idx1} >= reg_lo[0]) && ({1'b0, idx1} < reg_hi[0]);
   assign in_g = ({1'b0, idx1} >= reg_lo[1]) && ({1'b0, idx1} < reg_hi[1]);
   assign off_mod = in_o ? wo_if.rdata[15:0] : OFF_NEUTRAL;
   assign gain_mod = in_g ? wg_if.rdata[15:0] : GAIN_UNITY;
   assign off_sum = $signed({6'b000000, pix1}) - $signed({2'b00, FAC_OFF})
                    - $signed({{2{off_mod[15]}}, off_mod});
   assign oc = !shade_enable[0] ? pix1 :
               off_sum < 0 ? '0 : (off_sum > 18'sh00FFF) ? PIX_MAX : off_sum[PIX_W-1:0];
   assign prod = 44'(oc) * 44'(FAC_GAIN) * 44'(gain_mod);
   assign gprod = prod >> (2 * FRAC);
   assign gc = !shade_enable[1] ? oc : (gprod > 44'(PIX_MAX)) ? PIX_MAX : gprod[PIX_W-1:0];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         v1 <= 1'b0;
         pix1 <= '0;
         idx1 <= '0;
         corr_valid <= 1'b0;
         corr_data <= '0;
         corr_index <= '0;
      end else begin
         v1 <= pix_valid;
         pix1 <= pix_data;
         idx1 <= pix_index;
         corr_valid <= v1;
         corr_data <= gc;
         corr_index <= idx1;
      end
   end

   // build length counter; the walk is too long for a delay range
   logic [IDX_W:0] build_cyc;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         build_cyc <= '0;
      end else begin
         build_cyc <= (state == SQ_BUILD) ? build_cyc + 12'h001 : 12'h000;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   create_off_a: assert property ((state == SQ_ACCUM) && line_done && last_line |=>
      create_ctl[ctype] == CREATE_OFF && state == SQ_BUILD) else $error("create not cleared");
   build_auto_a: assert property ($fell(state == SQ_BUILD) |-> state == SQ_IDLE
      && $past(build_cyc) == NPIX_C && nv_valid[$past(ctype)])
      else $error("build did not finish");
   factory_prot_a: assert property (nv_if.we |-> state == SQ_BUILD && create_ctl == 2'b00)
      else $error("store written outside build");
   line_count_a: assert property ((state == SQ_ACCUM) && line_done && !last_line |=>
      lines == $past(lines) + 16'h0001) else $error("line not counted");
   retrig_ign_a: assert property ((state == SQ_ACCUM) && |(trig & create_ctl) |=>
      state == SQ_ACCUM && $stable(ctype)) else $error("retrigger disturbed create");
   act_copy_a: assert property ((wo_if.we || wg_if.we) |-> state == SQ_ACT
      && wo_if.waddr == $past(widx[IDX_W-1:0])) else $error("working copy misplaced");
   fac_create_a: assert property ((state == SQ_IDLE) && |trig && set_select[trig_t] == SET_FACTORY
      |=> status[$past(trig_t)] == ST_CREATE_ERROR && create_ctl == 2'b00)
      else $error("factory create not refused");
   ratio_err_a: assert property ((state == SQ_BUILD) && walk_end && ratio_bad |=>
      status[$past(ctype)] == ST_CREATE_ERROR) else $error("ratio error lost");
   over_write_a: assert property (nv_if.we |-> nv_if.waddr[AW-1] == ctype)
      else $error("wrong type overwritten");
   region_neutral_a: assert property (v1 && !in_o && shade_enable == 2'b01 |=>
      corr_data == (($past(pix1) > 12'(FAC_OFF)) ? $past(pix1) - 12'(FAC_OFF) : 12'h000))
      else $error("modifier outside region");
   pass_thru_a: assert property (v1 && shade_enable == 2'b00 |=> corr_data == $past(pix1))
      else $error("disabled correction changed pixel");
   cov_offset_c: cover property ((state == SQ_BUILD) && walk_end && ctype == TYPE_OFFSET);
   cov_gain_c: cover property ((state == SQ_BUILD) && walk_end && ctype == TYPE_GAIN);
   cov_act_c: cover property ((state == SQ_ACT) && walk_end && act_ok);
   cov_refuse_c: cover property ((state == SQ_ACCUM) && |(trig & ~create_ctl));
endmodule : ssc_shading_ctl
`default_nettype wire

// file: ssc_shading_ctl_tb.sv
// ssc_shading_ctl_tb: self-checking bench for the shading set controller.
// assumes ssc_pkg; the bench drives every control and pixel port itself.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %0t: mismatch got %h exp %h", $time, g, e); end end

module ssc_shading_ctl_tb import ssc_pkg::*;;
   localparam int RLO = 8;
   localparam int RHI = 24;
   logic core_clk, resetn, create_write_value, busy, pix_valid, line_done, corr_valid;
   logic [1:0] shade_enable, set_select, startup_set, activate, create_write, create_ctl;
   logic [3:0] shade_status;
   logic [IDX_W-1:0] region_horizontal_start, pix_index, corr_index;
   logic [IDX_W:0] region_width;
   logic [PIX_W-1:0] pix_data, corr_data;
   logic [1:0] pv_d;
   int err_total, comparisons;
   int line_pix [32];
   int dark [32];
   int wk_dark [32]; // model of the working offset copy
   bit wk_on;
   bit en_off; // offset correction enabled in the model
   int exp_q [$];

   // short counts keep the run small: 4 lines slow, 8 lines fast
   ssc_shading_ctl #(.MIN_LINES_LOG2(2), .FAST_PERIOD_CYC(50)) dut (
      .core_clk(core_clk), .resetn(resetn), .shade_enable(shade_enable),
      .set_select(set_select), .startup_set(startup_set), .activate(activate),
      .create_write(create_write), .create_write_value(create_write_value),
      .create_ctl(create_ctl), .shade_status(shade_status), .busy(busy),
      .region_horizontal_start(region_horizontal_start), .region_width(region_width),
      .pix_valid(pix_valid), .pix_data(pix_data), .pix_index(pix_index),
      .line_done(line_done), .corr_valid(corr_valid), .corr_data(corr_data),
      .corr_index(corr_index));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // expected pixel: factory offset whenever en_off is set, operator offset only in its region
   function automatic int exp_of(int i, int p);
      int v;
      v = en_off ? p - int'(FAC_OFF) : p;
      if (en_off && wk_on && i >= RLO && i < RHI) v = v - (wk_dark[i] - int'(FAC_OFF));
      if (v < 0) v = 0;
      if (v > 12'hFFF) v = 12'hFFF;
      return i * 4096 + v;
   endfunction : exp_of

   // latency and value of every corrected pixel, sampled mid-cycle
   always @(negedge core_clk) begin
      int e;
      if (resetn === 1'b1) begin
         `CHK(corr_valid, pv_d[1])
         if (corr_valid === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK({corr_index, corr_data}, e[22:0])
         end
      end
      pv_d <= {pv_d[0], pix_valid};
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // bounded wait for the sequencer; returns at a falling edge
   task automatic wait_idle();
      int k;
      k = 0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      while (busy !== 1'b0 && k < 9000) begin
         @(negedge core_clk);
         k++;
      end
      if (k == 9000) begin
         err_total++;
         $display("ERROR %0t: busy stuck", $time);
         give_verdict();
      end
   endtask : wait_idle

   // one-cycle pulse on create (cr=1) or activate; an extra edge avoids reassigning
   task automatic pulse(bit cr, logic [1:0] t);
      if (cr) create_write <= t;
      else activate <= t;
      @(posedge core_clk);
      create_write <= 2'b00;
      activate <= 2'b00;
      @(posedge core_clk);
   endtask : pulse

   // last n pixels of line_pix, then line_done, then gap idle cycles
   task automatic send_line(int n, int gap);
      for (int i = 32 - n; i < 32; i++) begin
         pix_valid <= 1'b1;
         pix_index <= IDX_W'(i);
         pix_data <= PIX_W'(line_pix[i]);
         exp_q.push_back(exp_of(i, line_pix[i]));
         @(posedge core_clk);
      end
      pix_valid <= 1'b0;
      line_done <= 1'b1;
      @(posedge core_clk);
      line_done <= 1'b0;
      repeat (gap) @(posedge core_clk);
   endtask : send_line

   task automatic rand_line();
      foreach (line_pix[i]) line_pix[i] = $urandom_range(0, 12'hFFF);
      send_line(32, 2);
   endtask : rand_line

   // activate the selected offset set and check its status
   task automatic act_offset(logic [1:0] sel, logic [1:0] st);
      set_select <= sel;
      pulse(1'b0, 2'b01);
      wait_idle();
      `CHK(shade_status[1:0], st)
      @(posedge core_clk);
   endtask : act_offset

   initial begin
      resetn = 1'b0;
      shade_enable = 2'b01;
      set_select = 2'b00;
      startup_set = 2'b10;
      activate = 2'b00;
      create_write = 2'b00;
      create_write_value = 1'b1;
      region_horizontal_start = 11'h008;
      region_width = 12'h010;
      pix_valid = 1'b0;
      pix_data = 12'h000;
      pix_index = 11'h000;
      line_done = 1'b0;
      pv_d = 2'b00;
      en_off = 1'b1;
      err_total = 0;
      comparisons = 0;
      wk_on = 1'b0;
      void'($urandom(59551));
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      // startup: offset factory loads clean, gain operator was never stored
      // busy drops for one cycle between the two startup loads
      wait_idle();
      wait_idle();
      `CHK(shade_status, 4'b0100)
      `CHK(create_ctl, 2'b00)
      @(posedge core_clk);
      act_offset(2'b01, 2'b10);
      // create on the factory set is refused
      set_select <= 2'b00;
      pulse(1'b1, 2'b01);
      @(negedge core_clk);
      `CHK(shade_status[1:0], 2'b11)
      `CHK(create_ctl, 2'b00)
      @(posedge core_clk);
      // an Off write on an operator set starts nothing
      set_select <= 2'b01;
      create_write_value <= 1'b0;
      pulse(1'b1, 2'b01);
      @(negedge core_clk);
      `CHK(busy, 1'b0)
      `CHK(create_ctl, 2'b00)
      @(posedge core_clk);
      create_write_value <= 1'b1;
      $display("test startup and refusals done");
      // two offset creates in darkness; the second overwrites the first
      for (int r = 0; r < 2; r++) begin
         foreach (line_pix[i]) line_pix[i] = 12'h010 + $urandom_range(0, 12'h07F);
         dark = line_pix;
         set_select <= 2'b01;
         pulse(1'b1, 2'b01);
         pulse(1'b1, 2'b01);
         pulse(1'b1, 2'b10);
         @(negedge core_clk);
         `CHK(create_ctl, 2'b01)
         `CHK(busy, 1'b1)
         `CHK(shade_status[3:2], 2'b11)
         @(posedge core_clk);
         repeat (2100) @(posedge core_clk);
         for (int l = 1; l <= 4; l++) begin
            send_line(32, 30);
            @(negedge core_clk);
            `CHK(create_ctl[0], l < 4)
            @(posedge core_clk);
            // retrigger of the running type mid-accumulation must be ignored
            if (l == 2) pulse(1'b1, 2'b01);
         end
         wait_idle();
         `CHK(shade_status[1:0], 2'b00)
         @(posedge core_clk);
         rand_line();
         act_offset(2'b01, 2'b00);
         wk_dark = dark;
         wk_on = 1'b1;
         rand_line();
         $display("test offset create round %0d done", r);
      end
      // gain create on white with one deep pixel, fast lines need twice the count
      foreach (line_pix[i]) line_pix[i] = 12'hF00;
      line_pix[20] = 12'h100;
      set_select <= 2'b11;
      // gain operator never stored yet: activation reports an error first
      pulse(1'b0, 2'b10);
      wait_idle();
      `CHK(shade_status[3:2], 2'b10)
      @(posedge core_clk);
      pulse(1'b1, 2'b10);
      repeat (2100) @(posedge core_clk);
      for (int l = 1; l <= 8; l++) begin
         send_line(16, 0);
         @(negedge core_clk);
         `CHK(create_ctl[1], l < 8)
         @(posedge core_clk);
      end
      wait_idle();
      `CHK(shade_status, 4'b1100)
      @(posedge core_clk);
      $display("test gain create done");
      // factory offset set is untouched by the creates
      act_offset(2'b00, 2'b00);
      wk_on = 1'b0;
      rand_line();
      // both corrections off: pixels pass through untouched
      shade_enable <= 2'b00;
      en_off = 1'b0;
      rand_line();
      repeat (6) @(posedge core_clk);
      $display("test factory set done");
      give_verdict();
   end
endmodule : ssc_shading_ctl_tb
`default_nettype wire
